// ---- verilog/seea_regs.svh ----
`ifndef SEEA_REGS_SVH
`define SEEA_REGS_SVH
// slave address device type codes
`define SEEA_DEV_ARRAY    4'hA
`define SEEA_DEV_CTRL     4'hB
`define SEEA_DEV_ZERO     2'h0
// control byte field positions
`define SEEA_WEL_BIT      1
`define SEEA_REGISTER_WRITE_LATCH_BIT     2
`define SEEA_BP0_BIT      0
`define SEEA_BP1_BIT      3
`define SEEA_BP2_BIT      4
`define SEEA_WD0_BIT      6
`define SEEA_WD1_BIT      7
// control commands
`define SEEA_CMD_SET_WEL  8'h02
`define SEEA_CMD_SET_REGISTER_WRITE_LATCH 8'h06
`define SEEA_CMD_CLR_WEL  8'h00
// nonvolatile bit mask and reset values
`define SEEA_NV_MASK      8'hD9
`define SEEA_NV_RST       8'hC0
`define SEEA_MEM_RST      8'hFF
// timing
`define SEEA_CLK_MHZ      100
`define SEEA_TWC_US       5000
`define SEEA_PURST_US     100
`define SEEA_TWC_CYC      (`SEEA_TWC_US * `SEEA_CLK_MHZ)
`define SEEA_PURST_CYC    (`SEEA_PURST_US * `SEEA_CLK_MHZ)
`endif

// ---- verilog/seea_pkg.sv ----
package seea_pkg;
  // protocol states, gray along the usual path
  typedef enum logic [3:0] {
    st_idle     = 4'h0,
    st_devadr   = 4'h1,
    st_ack_dev  = 4'h3,
    st_word     = 4'h2,
    st_ack_word = 4'h6,
    st_data     = 4'h7,
    st_ack_data = 4'h5,
    st_rd_byte  = 4'h4,
    st_rd_ack   = 4'hC
  } seea_state_t;
  // pending control register action, applied at stop
  typedef enum logic [2:0] {
    op_none     = 3'h0,
    op_set_wel  = 3'h1,
    op_clr_wel  = 3'h3,
    op_set_register_write_latch = 3'h2,
    op_keep     = 3'h6,
    op_nv       = 3'h7
  } seea_op_t;
  // status bits seen by the system
  typedef struct packed {
    logic       busy;
    logic       write_enable_latch;
    logic       register_write_latch;
    logic [1:0] wd;
    logic [2:0] bp;
  } seea_status_t;
endpackage : seea_pkg

// ---- verilog/seea_top.sv ----
`timescale 1ns/1ps
`include "seea_regs.svh"
// How it works
// RQ1: power-up: standby, latch clear, reset output pulsed
// RQ2: byte write acked, programmed after stop
// RQ3: busy cycle ignores bus, data released
// RQ4: protected address: no ack, no program
// RQ5: page write wraps low address bits only
// RQ6: extra page bytes overwrite wrapped location
// RQ7: stop mid byte or early: no program
// RQ8: polling gets ack only when not busy
// RQ9: read/write bit selects operation
// RQ10: address counter holds last address plus one
// RQ11: current read: ack, eight bits, release
// RQ12: master ends read by nack then stop
// RQ13: random read: dummy write, repeated start
// RQ14: stop after word address loads counter only
// RQ15: sequential read wraps top to zero
// RQ16: writes refused unless write enable latch set
// RQ17: protect pin blocks array and control writes
// RQ18: low supply aborts and ignores bus
// RQ19: nonvolatile settings need three-step sequence
// RQ20: 02H, 06H, then settings write
// RQ21: device type 1010 array, 1011 control
// RQ22: counter times write cycle, busy throughout
module seea_top #(
  parameter int ADDR_W    = 9,
  parameter int PAGE_W    = 4,
  parameter int TWC_CYC   = `SEEA_TWC_CYC,
  parameter int PURST_CYC = `SEEA_PURST_CYC
) (
  // system clock and reset
  input  wire logic           clk,
  input  wire logic           sys_rst,
  // serial link clock
  input  wire logic           scl_clk,
  // serial data pin
  input  wire logic           sda_i,
  output logic                sda_o,
  output logic                sda_oe,
  // protection and supply
  input  wire logic           wp_i,
  input  wire logic           vcc_low_i,
  // status
  output logic                rst_out,
  output seea_pkg::seea_status_t status
);
  import seea_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;  // array bytes
  localparam int PG    = 1 << PAGE_W;  // page bytes

  // parameters the logic cannot serve
  if (ADDR_W > 9 || ADDR_W < PAGE_W + 4 || PAGE_W < 1 || TWC_CYC < 2
      || PURST_CYC < 2) begin : g_bad_param
    $error("seea_top: unsupported parameter values");
  end

  ////////////////////////////////////////////////////////////////////
  // link domain: sample data on each link clock rise

  typedef struct packed {
    logic smp;  // data bit seen at the rise
    logic tog;  // flips once per rise
  } seea_link_t;

  seea_link_t lnk_q, lnk_d;

  // next link state
  always_comb begin
    lnk_d     = lnk_q;
    lnk_d.smp = sda_i;
    lnk_d.tog = ~lnk_q.tog;
  end

  // link registers
  always_ff @(posedge scl_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lnk_q <= '0;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // system domain state

  typedef struct packed {
    logic [2:0]             scl_s;   // [0] first flop, [2] previous
    logic [2:0]             sda_s;   // same layout
    logic [2:0]             tog_s;   // link toggle sync
    logic [1:0]             wp_s;    // protect pin sync
    logic [1:0]             vl_s;    // low supply sync
    seea_state_t            st;      // protocol state
    logic [2:0]             cnt;     // bit count in byte
    logic [7:0]             sh;      // receive shifter
    logic [7:0]             tx;      // transmit shifter
    logic                   ctl_sel; // control register chosen
    logic                   rw;      // read selected
    logic                   amsb;    // address msb from slave byte
    logic                   ack;     // answer for the ninth clock
    logic                   have;    // a data byte fully acked
    logic [ADDR_W-1:0]      addr;    // address counter
    seea_op_t               op;      // pending control action
    logic [7:0]             ctl_val; // pending control byte
    logic [7:0]             ctrl;    // nonvolatile control bits
    logic                   write_enable_latch;     // write enable latch
    logic                   register_write_latch;    // register write latch
    logic                   nv_ctl;  // cycle targets control
    logic                   busy;    // write cycle running
    logic [31:0]            tmr;     // write cycle timer
    logic [31:0]            por;     // power-up reset timer
    logic                   rst_out; // reset output
    logic                   oe;      // pulling data low
    logic [PG-1:0]          pg_v;    // page buffer valid
    logic [PG-1:0][7:0]     pg;      // page buffer
    logic [DEPTH-1:0][7:0]  mem;     // the array
  } seea_core_t;

  seea_core_t q, d;

  // bus events, decoded from synchronised pins
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       rbit;
  logic [7:0] b;
  logic       ok;

  // protected region check from the block protect bits
  function automatic logic seea_prot(input logic [2:0] bp,
                                     input logic [ADDR_W-1:0] a);
    case (bp)
      3'h1:    seea_prot = a[ADDR_W-1] & a[ADDR_W-2];
      3'h2:    seea_prot = a[ADDR_W-1];
      3'h3:    seea_prot = 1'b1;
      3'h4:    seea_prot = (a >> PAGE_W) == '0;
      3'h5:    seea_prot = (a >> (PAGE_W + 1)) == '0;
      3'h6:    seea_prot = (a >> (PAGE_W + 2)) == '0;
      3'h7:    seea_prot = (a >> (PAGE_W + 3)) == '0;
      default: seea_prot = 1'b0;
    endcase
  endfunction : seea_prot

  // control register image for reads
  function automatic logic [7:0] seea_img(input logic [7:0] c,
                                          input logic w, input logic r);
    logic [7:0] v;
    v = c & `SEEA_NV_MASK;
    v[`SEEA_WEL_BIT]  = w;
    v[`SEEA_REGISTER_WRITE_LATCH_BIT] = r;
    seea_img = v;
  endfunction : seea_img

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d     = q;
    rise  = q.tog_s[2] ^ q.tog_s[1];
    fall  = q.scl_s[2] & ~q.scl_s[1];
    start = q.scl_s[2] & q.scl_s[1] & q.sda_s[2] & ~q.sda_s[1];
    stop  = q.scl_s[2] & q.scl_s[1] & ~q.sda_s[2] & q.sda_s[1];
    rbit  = lnk_q.smp;  // stable while the toggle is new
    b     = {q.sh[6:0], rbit};
    ok    = 1'b0;
    // synchronisers
    d.scl_s = {q.scl_s[1:0], scl_clk};
    d.sda_s = {q.sda_s[1:0], sda_i};
    d.tog_s = {q.tog_s[1:0], lnk_q.tog};
    d.wp_s  = {q.wp_s[0], wp_i};
    d.vl_s  = {q.vl_s[0], vcc_low_i};
    // power-up reset output
    if (q.por != 32'h0) begin
      d.por = q.por - 32'h1;  // [RQ1]
    end
    d.rst_out = (d.por != 32'h0);  // [RQ1]
    // write cycle timer, then commit
    if (q.busy) begin
      d.tmr = q.tmr - 32'h1;  // [RQ22]
      if (q.tmr == 32'h1) begin
        d.busy = 1'b0;  // [RQ22]
        if (q.nv_ctl) begin
          d.ctrl = q.ctl_val & `SEEA_NV_MASK;  // [RQ20]
          d.register_write_latch = 1'b0;  // [RQ20]
        end else begin
          for (int i = 0; i < PG; i++) begin
            if (q.pg_v[i]) begin
              d.mem[{q.addr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] = q.pg[i];  // [RQ2]
            end
          end
        end
      end
    end
    // release data pin on every fall unless a state drives it
    if (fall) begin
      d.oe = 1'b0;
    end
    if (q.vl_s[1]) begin
      // low supply: drop any transfer
      d.st = st_idle;  // [RQ18]
      d.oe = 1'b0;  // [RQ18]
    end else if (q.busy) begin
      // inputs disabled, no answer to polling
      d.st = st_idle;  // [RQ3] [RQ8]
      d.oe = 1'b0;  // [RQ3]
    end else if (start) begin
      // start or repeated start
      d.st   = st_devadr;
      d.cnt  = 3'h0;
      d.oe   = 1'b0;
      d.have = 1'b0;
      d.op   = op_none;
      d.pg_v = '0;
    end else if (stop) begin
      // one rise precedes every stop, so cnt up to one is clean
      if (q.st == st_data && q.cnt <= 3'h1 && q.have) begin  // [RQ7]
        if (q.ctl_sel) begin
          case (q.op)
            op_set_wel:  d.write_enable_latch  = 1'b1;
            op_clr_wel:  d.write_enable_latch  = 1'b0;
            op_set_register_write_latch: d.register_write_latch = 1'b1;  // [RQ20]
            op_nv: begin
              d.busy   = 1'b1;  // [RQ19]
              d.nv_ctl = 1'b1;
              d.tmr    = 32'(TWC_CYC);  // [RQ22]
            end
            default: d.op = op_none;
          endcase
        end else begin
          d.busy   = 1'b1;  // [RQ2]
          d.nv_ctl = 1'b0;
          d.tmr    = 32'(TWC_CYC);  // [RQ22]
        end
      end
      // stop after word address alone just keeps the counter
      d.st = st_idle;  // [RQ14] [RQ7]
      d.oe = 1'b0;
    end else begin
      case (q.st)
        // slave address byte
        st_devadr: begin
          if (rise) begin
            d.sh  = b;
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == 3'h7) begin
              d.ctl_sel = (b[7:4] == `SEEA_DEV_CTRL);  // [RQ21]
              d.ack     = (b[7:4] == `SEEA_DEV_ARRAY || b[7:4] == `SEEA_DEV_CTRL)
                          && b[3:2] == `SEEA_DEV_ZERO;  // [RQ21]
              d.rw      = b[0];  // [RQ9]
              d.amsb    = b[1];
              d.st      = st_ack_dev;
            end
          end
        end
        // answer the slave address
        st_ack_dev: begin
          if (fall) begin
            d.oe = q.ack;  // [RQ8] [RQ21]
          end else if (rise) begin
            d.cnt = 3'h0;
            if (!q.ack) begin
              d.st = st_idle;  // [RQ21]
            end else if (q.rw) begin
              d.st = st_rd_byte;  // [RQ11]
              if (q.ctl_sel) begin
                d.tx = seea_img(q.ctrl, q.write_enable_latch, q.register_write_latch);
              end else begin
                d.tx   = q.mem[q.addr];  // [RQ11]
                d.addr = q.addr + ADDR_W'(1);  // [RQ10]
              end
            end else begin
              d.st = st_word;  // [RQ9]
            end
          end
        end
        // word address byte
        st_word: begin
          if (rise) begin
            d.sh  = b;
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == 3'h7) begin
              d.addr = ADDR_W'({q.amsb, b});  // [RQ10] [RQ13]
              d.ack  = 1'b1;  // [RQ2]
              d.st   = st_ack_word;
            end
          end
        end
        // answer the word address
        st_ack_word: begin
          if (fall) begin
            d.oe = q.ack;  // [RQ2]
          end else if (rise) begin
            d.cnt = 3'h0;
            d.st  = st_data;
          end
        end
        // data byte for array or control register
        st_data: begin
          if (rise) begin
            d.sh  = b;
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == 3'h7) begin
              d.st = st_ack_data;
              if (!q.ctl_sel) begin
                ok = q.write_enable_latch && !q.wp_s[1]  // [RQ16] [RQ17]
                     && !seea_prot({q.ctrl[`SEEA_BP2_BIT], q.ctrl[`SEEA_BP1_BIT],
                                    q.ctrl[`SEEA_BP0_BIT]}, q.addr);  // [RQ4]
                if (ok) begin
                  d.pg[q.addr[PAGE_W-1:0]]   = b;  // [RQ6]
                  d.pg_v[q.addr[PAGE_W-1:0]] = 1'b1;
                  d.addr[PAGE_W-1:0] = q.addr[PAGE_W-1:0] + PAGE_W'(1);  // [RQ5]
                end else if (q.write_enable_latch && !q.wp_s[1]) begin
                  d.register_write_latch = 1'b0;  // [RQ4]
                end
              end else if (q.have || q.wp_s[1]) begin
                ok = 1'b0;  // [RQ17]
              end else if (q.write_enable_latch && q.register_write_latch) begin
                ok        = 1'b1;  // [RQ19]
                d.ctl_val = b;
                d.op      = b[`SEEA_REGISTER_WRITE_LATCH_BIT] ? op_keep : op_nv;  // [RQ20]
              end else if (b == `SEEA_CMD_SET_WEL) begin
                ok   = 1'b1;  // [RQ20]
                d.op = op_set_wel;
              end else if (b == `SEEA_CMD_SET_REGISTER_WRITE_LATCH && q.write_enable_latch) begin
                ok   = 1'b1;  // [RQ20]
                d.op = op_set_register_write_latch;
              end else if (b == `SEEA_CMD_CLR_WEL && q.write_enable_latch) begin
                ok   = 1'b1;
                d.op = op_clr_wel;
              end else begin
                ok = 1'b0;  // [RQ16] [RQ19]
              end
              d.ack = ok;
            end
          end
        end
        // answer the data byte
        st_ack_data: begin
          if (fall) begin
            d.oe = q.ack;  // [RQ2] [RQ4] [RQ5]
          end else if (rise) begin
            d.cnt = 3'h0;
            if (q.ack) begin
              d.have = 1'b1;  // [RQ7]
              d.st   = st_data;
            end else begin
              d.st = st_idle;  // [RQ4]
            end
          end
        end
        // shift a read byte out, msb first
        st_rd_byte: begin
          if (fall) begin
            d.oe = ~q.tx[7];  // [RQ11]
          end else if (rise) begin
            d.tx  = {q.tx[6:0], 1'b0};
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == 3'h7) begin
              d.st = st_rd_ack;  // [RQ11]
            end
          end
        end
        // ninth clock: line released, watch master answer
        st_rd_ack: begin
          if (rise) begin
            d.cnt = 3'h0;
            if (!rbit) begin
              d.st = st_rd_byte;  // [RQ15]
              if (q.ctl_sel) begin
                d.tx = seea_img(q.ctrl, q.write_enable_latch, q.register_write_latch);
              end else begin
                d.tx   = q.mem[q.addr];  // [RQ15]
                d.addr = q.addr + ADDR_W'(1);  // [RQ15]
              end
            end else begin
              d.st = st_idle;  // [RQ12]
            end
          end
        end
        default: d.st = st_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // system registers

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q         <= '0;
      q.st      <= st_idle;  // [RQ1]
      q.op      <= op_none;
      q.ctrl    <= `SEEA_NV_RST;
      q.write_enable_latch     <= 1'b0;  // [RQ1]
      q.por     <= 32'(PURST_CYC);
      q.rst_out <= 1'b1;  // [RQ1]
      q.mem     <= {DEPTH{`SEEA_MEM_RST}};
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign sda_o       = 1'b0;  // open drain: only ever pulls low
  assign sda_oe      = q.oe;
  assign rst_out     = q.rst_out;
  assign status.busy = q.busy;
  assign status.write_enable_latch  = q.write_enable_latch;
  assign status.register_write_latch = q.register_write_latch;
  assign status.wd   = {q.ctrl[`SEEA_WD1_BIT], q.ctrl[`SEEA_WD0_BIT]};
  assign status.bp   = {q.ctrl[`SEEA_BP2_BIT], q.ctrl[`SEEA_BP1_BIT],
                        q.ctrl[`SEEA_BP0_BIT]};

endmodule : seea_top

// ---- dv/seea_master.sv ----
`timescale 1ns/1ps
// bus master model: paces the serial clock from the system clock
module seea_master (
  // pacing clock
  input  wire logic clk,
  // serial pins seen from the master
  output logic      scl_clk,
  output logic      sda_low,
  input  wire logic sda
);
  // clock rests high, data left to the pull-up
  initial begin
    scl_clk = 1'b1;
    sda_low = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  // wait n falling edges
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask : gap
  // start or repeated start; long lead lets the slave drop its ack first
  task automatic start();
    gap(3);
    sda_low = 1'b0;
    gap(3);
    scl_clk = 1'b1;
    gap(2);
    sda_low = 1'b1;
    gap(2);
    scl_clk = 1'b0;
  endtask : start
  // stop after a whole byte and its ack, or mid byte only to abort
  task automatic stop();
    gap(3);
    sda_low = 1'b1;
    gap(3);
    scl_clk = 1'b1;
    gap(2);
    sda_low = 1'b0;
    gap(4);
  endtask : stop
  // one bit: data set while low, line sampled mid-high; 80 ns link period
  task automatic xbit(input logic b, output logic r);
    gap(2);
    sda_low = ~b;
    gap(2);
    scl_clk = 1'b1;
    gap(2);
    r = sda;
    gap(2);
    scl_clk = 1'b0;
  endtask : xbit
  // byte out msb first, returns the ack of the ninth clock
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, r);
    ack = ~r;
  endtask : send
  // byte in; more=0 keeps the line high in the ninth clock to end a read
  task automatic recv(output logic [7:0] d, input logic more);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(~more, r);
  endtask : recv
endmodule : seea_master

// ---- dv/seea_checker.sv ----
`timescale 1ns/1ps
// port-level checks on the access block
module seea_checker #(
  parameter int TWC_CYC   = 20,
  parameter int PURST_CYC = 10
) (
  // clocks and reset
  input wire logic                   clk,
  input wire logic                   sys_rst,
  input wire logic                   scl_clk,
  // serial data pin
  input wire logic                   sda_i,
  input wire logic                   sda_o,
  input wire logic                   sda_oe,
  // protection and supply
  input wire logic                   wp_i,
  input wire logic                   vcc_low_i,
  // status
  input wire logic                   rst_out,
  input wire seea_pkg::seea_status_t status
);
  import seea_pkg::*;
  // helper counters
  typedef struct packed {
    logic [31:0] rst_cnt;  // cycles since reset release
    logic [31:0] busy_cnt; // length of the running busy stretch
  } seea_chk_t;
  seea_chk_t chk_q;
  seea_chk_t chk_d;
  // next counter values
  always_comb begin
    chk_d = chk_q;
    if (chk_q.rst_cnt < 32'hFFFF) chk_d.rst_cnt = chk_q.rst_cnt + 32'h1;
    chk_d.busy_cnt = status.busy ? chk_q.busy_cnt + 32'h1 : 32'h0;
  end
  // counter registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) chk_q <= '0;
    else chk_q <= chk_d;
  end
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  chk_rst_hold: assert property (chk_q.rst_cnt < PURST_CYC - 1 |-> rst_out)
    else $error("reset output dropped early");
  chk_rst_end: assert property (chk_q.rst_cnt > PURST_CYC + 2 |-> !rst_out)
    else $error("reset output held too long");
  chk_busy_quiet: assert property (status.busy |-> !sda_oe)
    else $error("data driven during write cycle");
  chk_low_quiet: assert property (vcc_low_i [*6] |-> !sda_oe)
    else $error("data driven at low supply");
  chk_busy_max: assert property (status.busy |-> chk_q.busy_cnt < TWC_CYC + 1)
    else $error("write cycle too long");
  chk_busy_min: assert property ($fell(status.busy) |-> chk_q.busy_cnt >= TWC_CYC - 1)
    else $error("write cycle too short");
  chk_write_wel: assert property ($rose(status.busy) |-> $past(status.write_enable_latch))
    else $error("write cycle without enable latch");
  chk_write_wp: assert property ($rose(status.busy) |-> !$past(wp_i, 4))
    else $error("write cycle while protected");
  chk_register_write_latch_wel: assert property ($rose(status.register_write_latch) |-> $past(status.write_enable_latch))
    else $error("register latch set without enable latch");
  chk_nv_slot: assert property (($changed(status.bp) || $changed(status.wd)) |->
    $past(status.busy) || $past(status.busy, 2))
    else $error("settings changed outside a write cycle");
endmodule : seea_checker

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import seea_pkg::*;
  localparam int TWC   = 400; // shortened write cycle
  localparam int PURST = 10;  // shortened power-up reset
  // clock, reset and pins
  logic         clk = 1'b0;
  logic         sys_rst;
  logic         wp_i;
  logic         vcc_low_i;
  wire logic    scl_clk;
  wire logic    sda_low;
  wire logic    sda;
  logic         sda_o;
  logic         sda_oe;
  logic         rst_out;
  seea_status_t status;
  // array mirror, expected counter and tallies
  logic [7:0]   mem [0:511];
  logic [8:0]   cur;
  int           num_errors = 0;
  int           checked = 0;
  always #5 clk = ~clk;
  // open-drain data line with pull-up
  assign sda = ~(sda_low | (sda_oe & ~sda_o));
  seea_master mst (.clk(clk), .scl_clk(scl_clk), .sda_low(sda_low), .sda(sda));
  seea_top #(.TWC_CYC(TWC), .PURST_CYC(PURST)) dut (
    .clk(clk), .sys_rst(sys_rst), .scl_clk(scl_clk), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .wp_i(wp_i), .vcc_low_i(vcc_low_i), .rst_out(rst_out),
    .status(status));
  //////////////////////////////////////////////////////////////////////
  // compare one flag
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: bit got %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  // compare one byte
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  // verdict and end of run
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  // send a byte and compare its ack
  task automatic wr_ack(input logic [7:0] d, input logic exp);
    logic a;
    mst.send(d, a);
    chk_bit(a, exp);
  endtask : wr_ack
  // start, write address and word byte, no stop
  task automatic setaddr(input logic [8:0] a);
    mst.start();
    wr_ack({4'hA, 2'b00, a[8], 1'b0}, 1'b1);
    wr_ack(a[7:0], 1'b1);
    cur = a;
  endtask : setaddr
  // bounded wait for the write cycle to finish
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (6) @(negedge clk);
    while (status.busy !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk_bit(status.busy, 1'b0);
  endtask : wait_idle
  // byte write; mirror follows only when the data is accepted
  task automatic bwrite(input logic [8:0] a, input logic [7:0] d, input logic ok);
    setaddr(a);
    wr_ack(d, ok);
    mst.stop();
    if (ok) mem[a] = d;
  endtask : bwrite
  // control register write, data ack left unjudged
  task automatic ctrl(input logic [7:0] d);
    logic a;
    mst.start();
    wr_ack(8'hB0, 1'b1);
    wr_ack(8'h00, 1'b1);
    mst.send(d, a);
    mst.stop();
    wait_idle();
  endtask : ctrl
  // read n bytes, from a or from the counter, against the mirror
  task automatic rd(input logic [8:0] a, input int n, input logic rnd);
    logic [7:0] d;
    if (rnd) setaddr(a);
    mst.start();
    wr_ack({4'hA, 2'b00, cur[8], 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      mst.recv(d, i < n - 1);
      chk_byte(d, mem[cur]);
      cur = cur + 9'h001;
    end
    mst.stop();
  endtask : rd
  // ack polling right after a write-ending stop
  task automatic poll();
    logic a;
    int n;
    a = 1'b0;
    n = 0;
    repeat (4) @(negedge clk);
    chk_bit(status.busy, 1'b1);
    while (a !== 1'b1 && n < 40) begin
      mst.start();
      mst.send(8'hA0, a);
      mst.stop();
      n++;
    end
    chk_bit(n > 1, 1'b1);
    chk_bit(a, 1'b1);
    wait_idle();
  endtask : poll
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic b;
    sys_rst = 1'b1;
    wp_i = 1'b0;
    vcc_low_i = 1'b0;
    cur = 9'h000;
    for (int i = 0; i < 512; i++) mem[i] = 8'hFF;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    chk_byte(status, 8'h18);
    chk_bit(rst_out, 1'b1);
    chk_bit(sda_oe, 1'b0);
    chk_bit(sda_o, 1'b0);
    repeat (PURST + 4) @(negedge clk);
    chk_bit(rst_out, 1'b0);
    bwrite(9'h010, 8'h5A, 1'b0);
    mst.start();
    wr_ack(8'hC0, 1'b0);
    mst.stop();
    mst.start();
    wr_ack(8'hA8, 1'b0);
    mst.stop();
    ctrl(8'h02);
    chk_byte(status, 8'h58);
    bwrite(9'h110, 8'h5A, 1'b1);
    poll();
    setaddr(9'h00A);
    for (int i = 0; i < 18; i++) begin
      wr_ack(8'h30 + i[7:0], 1'b1);
      mem[{5'h00, 4'hA + i[3:0]}] = 8'h30 + i[7:0];
    end
    mst.stop();
    poll();
    rd(9'h10F, 2, 1'b1);
    rd(9'h1FF, 17, 1'b1);
    rd(9'h000, 1, 1'b0);
    setaddr(9'h005);
    mst.stop();
    rd(9'h000, 1, 1'b0);
    setaddr(9'h040);
    repeat (4) mst.xbit(1'b0, b);
    mst.stop();
    wait_idle();
    rd(9'h040, 1, 1'b1);
    wp_i = 1'b1;
    bwrite(9'h041, 8'h11, 1'b0);
    wp_i = 1'b0;
    ctrl(8'h12);
    chk_byte(status, 8'h58);
    ctrl(8'h06);
    chk_byte(status, 8'h78);
    ctrl(8'h12);
    chk_byte(status, 8'h44);
    bwrite(9'h003, 8'h77, 1'b0);
    rd(9'h003, 1, 1'b1);
    vcc_low_i = 1'b1;
    mst.start();
    wr_ack(8'hA0, 1'b0);
    mst.stop();
    vcc_low_i = 1'b0;
    end_sim();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule : tb_top
bind seea_top seea_checker #(.TWC_CYC(TWC_CYC), .PURST_CYC(PURST_CYC)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .scl_clk(scl_clk), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .wp_i(wp_i), .vcc_low_i(vcc_low_i), .rst_out(rst_out),
  .status(status));
